// File: design/tfsb_pkg.sv
/*
 * package for the tape status byte block: byte indices, bit positions, sizes.
 * assumes nothing beyond a systemverilog compiler.
 */
package tfsb_pkg;
    localparam int unsigned FULL_BYTES = 16;
    localparam int unsigned COND_BYTES = 9;
    localparam int unsigned IDX_W = 4;
    // full block byte indices (byte n at index n-1)
    localparam logic [3:0] IDX_WR_CNT = 4'h0;
    localparam logic [3:0] IDX_RD_CNT = 4'h1;
    localparam logic [3:0] IDX_DIAG_NUM = 4'h2;
    localparam logic [3:0] IDX_DIAG_CODE = 4'h3;
    localparam logic [3:0] IDX_TRACK_MAP = 4'h4;
    localparam logic [3:0] IDX_RD_DETAIL = 4'h5;
    localparam logic [3:0] IDX_SUPP = 4'h6;
    localparam logic [3:0] IDX_COMMAND_UNFINISHED = 4'h7;
    localparam logic [3:0] IDX_REJECT = 4'h8;
    localparam logic [3:0] IDX_DENS_ERR = 4'h9;
    localparam logic [3:0] IDX_MOTION_LAST = 4'hb;
    localparam logic [3:0] IDX_DENS_CFG = 4'he;
    localparam logic [3:0] IDX_OPT_CFG = 4'hf;
    // condensed block: bytes 1..7 mirror full, then two config copies
    localparam logic [3:0] CIDX_LAST_MIRROR = 4'h6;
    localparam logic [3:0] CIDX_CFG = 4'h8;
    // read error detail bits
    localparam int unsigned RD_NRZ = 7;
    localparam int unsigned RD_IDENT = 6;
    localparam int unsigned RD_CORR = 5;
    localparam int unsigned RD_VPE_C = 4;
    localparam int unsigned RD_SKEW = 3;
    localparam int unsigned RD_MTD = 2;
    localparam int unsigned RD_FPOST = 1;
    localparam int unsigned RD_FPRE = 0;
    localparam int unsigned RD_LRC = 2;
    localparam int unsigned RD_CRC = 1;
    localparam int unsigned RD_VPE_N = 0;
    // supplementary status bits
    localparam int unsigned SS_REJECT = 7;
    localparam int unsigned SS_UNFIN = 6;
    localparam int unsigned SS_LIMIT = 5;
    localparam int unsigned SS_WARN = 4;
    localparam int unsigned SS_DENS = 3;
    localparam int unsigned SS_EOT = 2;
    localparam int unsigned SS_FMARK = 1;
    localparam int unsigned SS_PAR = 0;
    localparam int unsigned NO_READBACK_BIT = 7;
    localparam logic [7:0] IFACE_DIAG_MASK = 8'h1f;
    localparam logic [7:0] PANEL_DIAG_MASK = 8'h7f;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
endpackage

// File: design/tfsb_status.sv
/*
 * tape status byte block: sixteen full bytes and nine condensed bytes,
 * updated from drive events, read combinationally by index.
 * assumes all event inputs are single-cycle pulses from controller logic on
 * clock_i; only the host write strobe, data lines and parity come from pins.
 */
// Summary of operation
// - full block sixteen bytes, condensed nine bytes
// - power-up clears bytes, loads configuration bytes
// - accepted tape motion clears bytes five-twelve
// - clearing diagnostic clears, loads current density
// - count write hard and correctable errors
// - count on-line hard read errors
// - log diagnostic number, five or seven bits
// - on-line diagnostic failure code, zero none
// - off-line failure skip holds error count
// - track error map bit n track n
// - detail bit seven selects NRZ meaning
// - coded bit six ident burst found
// - coded bit five corrected, no hard line
// - coded bits four three two errors
// - false preamble sets bits zero and one
// - NRZ bits two one zero checks
// - bit seven reject, cause in byte nine
// - bit six unfinished, bit three density
// - bit five tape end limit
// - bit four warning, bit one file mark
// - bit two set forward, clear reverse
// - bit zero host write parity error
// - byte eight bit seven no readback
`timescale 1ns/1ps
`default_nettype none
module tfsb_status (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [7:0] density_cfg_i,
    input wire logic [7:0] option_cfg_i,
    input wire logic [7:0] current_density_i,
    input wire logic motion_accept_i,
    input wire logic clear_diag_i,
    input wire logic write_error_i,
    input wire logic read_hard_error_i,
    input wire logic diag_iface_i,
    input wire logic diag_panel_i,
    input wire logic [7:0] diag_number_i,
    input wire logic online_i,
    input wire logic diag_fail_i,
    input wire logic [7:0] diag_fail_code_i,
    input wire logic failure_skip_i,
    input wire logic skip_fail_i,
    input wire logic track_error_i,
    input wire logic [7:0] track_i,
    input wire logic nrz_active_i,
    input wire logic ident_found_i,
    input wire logic corrected_error_i,
    input wire logic uncorrected_error_i,
    input wire logic vertical_parity_error_i,
    input wire logic skew_error_i,
    input wire logic multi_track_dropout_i,
    input wire logic false_postamble_i,
    input wire logic false_preamble_i,
    input wire logic longitudinal_check_error_i,
    input wire logic cyclic_check_error_i,
    input wire logic reject_i,
    input wire logic [7:0] reject_cause_i,
    input wire logic unfinished_i,
    input wire logic [7:0] command_unfinished_cause_i,
    input wire logic no_readback_during_write_i,
    input wire logic density_error_i,
    input wire logic [7:0] density_error_cause_i,
    input wire logic tape_end_limit_i,
    input wire logic limit_inhibit_en_i,
    input wire logic tape_end_warning_i,
    input wire logic eot_forward_i,
    input wire logic eot_reverse_i,
    input wire logic file_mark_i,
    input wire logic block_traversed_i,
    input wire logic ext_write_parity_en_i,
    input wire logic host_write_strobe_i,
    input wire logic [7:0] host_write_data_lines_i,
    input wire logic host_write_parity_i,
    input wire logic [3:0] full_index_i,
    input wire logic [3:0] cond_index_i,
    output logic [7:0] full_data_o,
    output logic [7:0] cond_data_o,
    output logic hard_error_line_o,
    output logic forward_inhibit_o
);
    // ****************************************************************
    // storage and byte clear decode
    // ****************************************************************
    logic [7:0] status [tfsb_pkg::FULL_BYTES];
    logic [7:0] next_status [tfsb_pkg::FULL_BYTES];
    logic [8:0] pin_s1, pin_s2, pin_s3;
    logic [2:0] strobe_sync;

    function automatic logic motion_cleared(input logic [3:0] idx);
        return idx >= tfsb_pkg::IDX_TRACK_MAP && idx <= tfsb_pkg::IDX_MOTION_LAST;
    endfunction

    // ****************************************************************
    // host write data lines: three-stage synchroniser
    // ****************************************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            strobe_sync <= '0;
        end else begin
            pin_s1 <= {host_write_parity_i, host_write_data_lines_i};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            strobe_sync <= {strobe_sync[1:0], host_write_strobe_i};
        end
    end

    // odd parity over nine settled lines while the settled strobe is high
    logic par_bad;
    assign par_bad = strobe_sync[1] && strobe_sync[2] && (pin_s2 == pin_s3) && !(^pin_s3);

    // ****************************************************************
    // next value of every byte
    // ****************************************************************
    always_comb begin
        logic [7:0] rd;
        logic [7:0] ss;
        rd = '0;
        ss = '0;
        for (int i = 0; i < int'(tfsb_pkg::FULL_BYTES); i++) begin
            next_status[i] = status[i];
        end
        if (clear_diag_i) begin
            for (int i = 0; i < int'(tfsb_pkg::FULL_BYTES); i++) begin
                if (4'(i) != tfsb_pkg::IDX_DENS_CFG) begin
                    next_status[i] = tfsb_pkg::BYTE_ZERO;
                end
            end
            next_status[tfsb_pkg::IDX_DENS_CFG] = current_density_i;
        end else begin
            if (motion_accept_i) begin
                for (int i = 0; i < int'(tfsb_pkg::FULL_BYTES); i++) begin
                    if (motion_cleared(4'(i))) begin
                        next_status[i] = tfsb_pkg::BYTE_ZERO;
                    end
                end
            end
            if (write_error_i) begin
                next_status[tfsb_pkg::IDX_WR_CNT] =
                    status[tfsb_pkg::IDX_WR_CNT] + tfsb_pkg::BYTE_ONE;
            end
            if (read_hard_error_i && online_i) begin
                next_status[tfsb_pkg::IDX_RD_CNT] =
                    status[tfsb_pkg::IDX_RD_CNT] + tfsb_pkg::BYTE_ONE;
            end
            if (diag_panel_i) begin
                next_status[tfsb_pkg::IDX_DIAG_NUM] =
                    diag_number_i & tfsb_pkg::PANEL_DIAG_MASK;
            end else if (diag_iface_i) begin
                next_status[tfsb_pkg::IDX_DIAG_NUM] =
                    diag_number_i & tfsb_pkg::IFACE_DIAG_MASK;
            end
            if (!online_i && failure_skip_i) begin
                if (skip_fail_i) begin
                    next_status[tfsb_pkg::IDX_DIAG_CODE] =
                        status[tfsb_pkg::IDX_DIAG_CODE] + tfsb_pkg::BYTE_ONE;
                end
            end else if (diag_fail_i && online_i) begin
                next_status[tfsb_pkg::IDX_DIAG_CODE] = diag_fail_code_i;
            end
            // flags accumulate onto the (possibly just cleared) byte
            if (track_error_i && online_i) begin
                next_status[tfsb_pkg::IDX_TRACK_MAP] =
                    next_status[tfsb_pkg::IDX_TRACK_MAP] | track_i;
            end
            rd[tfsb_pkg::RD_NRZ] = nrz_active_i;
            if (nrz_active_i) begin
                rd[tfsb_pkg::RD_LRC] = longitudinal_check_error_i;
                rd[tfsb_pkg::RD_CRC] = cyclic_check_error_i;
                rd[tfsb_pkg::RD_VPE_N] = vertical_parity_error_i;
            end else begin
                rd[tfsb_pkg::RD_IDENT] = ident_found_i;
                rd[tfsb_pkg::RD_CORR] = corrected_error_i;
                rd[tfsb_pkg::RD_VPE_C] = vertical_parity_error_i;
                rd[tfsb_pkg::RD_SKEW] = skew_error_i;
                rd[tfsb_pkg::RD_MTD] = multi_track_dropout_i;
                rd[tfsb_pkg::RD_FPOST] = false_postamble_i | false_preamble_i;
                rd[tfsb_pkg::RD_FPRE] = false_preamble_i;
            end
            // density bit is a level; error bits stick
            next_status[tfsb_pkg::IDX_RD_DETAIL] =
                ((next_status[tfsb_pkg::IDX_RD_DETAIL] | rd)
                 & ~(8'h01 << tfsb_pkg::RD_NRZ)) | (rd & (8'h01 << tfsb_pkg::RD_NRZ));
            ss[tfsb_pkg::SS_REJECT] = reject_i;
            ss[tfsb_pkg::SS_UNFIN] = unfinished_i | no_readback_during_write_i;
            ss[tfsb_pkg::SS_LIMIT] = tape_end_limit_i;
            ss[tfsb_pkg::SS_WARN] = tape_end_warning_i;
            ss[tfsb_pkg::SS_DENS] = density_error_i;
            ss[tfsb_pkg::SS_EOT] = eot_forward_i;
            ss[tfsb_pkg::SS_PAR] = par_bad && ext_write_parity_en_i;
            next_status[tfsb_pkg::IDX_SUPP] = next_status[tfsb_pkg::IDX_SUPP] | ss;
            if (eot_reverse_i && !eot_forward_i) begin
                next_status[tfsb_pkg::IDX_SUPP][tfsb_pkg::SS_EOT] = 1'b0;
            end
            if (block_traversed_i) begin
                next_status[tfsb_pkg::IDX_SUPP][tfsb_pkg::SS_FMARK] = file_mark_i;
            end
            if (reject_i) begin
                next_status[tfsb_pkg::IDX_REJECT] = reject_cause_i;
            end
            if (unfinished_i || no_readback_during_write_i) begin
                next_status[tfsb_pkg::IDX_COMMAND_UNFINISHED] = next_status[tfsb_pkg::IDX_COMMAND_UNFINISHED]
                    | command_unfinished_cause_i
                    | ({7'h00, no_readback_during_write_i} << tfsb_pkg::NO_READBACK_BIT);
            end
            if (density_error_i) begin
                next_status[tfsb_pkg::IDX_DENS_ERR] = density_error_cause_i;
            end
        end
    end

    // ****************************************************************
    // byte registers; configuration bytes loaded after reset release
    // ****************************************************************
    logic cfg_pending;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_pending <= 1'b1;
        end else begin
            cfg_pending <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < int'(tfsb_pkg::FULL_BYTES); i++) begin
                status[i] <= tfsb_pkg::BYTE_ZERO;
            end
        end else begin
            for (int i = 0; i < int'(tfsb_pkg::FULL_BYTES); i++) begin
                status[i] <= next_status[i];
            end
            if (cfg_pending) begin
                status[tfsb_pkg::IDX_DENS_CFG] <= density_cfg_i;
                status[tfsb_pkg::IDX_OPT_CFG] <= option_cfg_i;
            end
        end
    end

    // ****************************************************************
    // read ports and side outputs
    // ****************************************************************
    always_comb begin
        full_data_o = status[full_index_i];
        if (cond_index_i <= tfsb_pkg::CIDX_LAST_MIRROR) begin
            cond_data_o = status[cond_index_i];
        end else if (cond_index_i == tfsb_pkg::CIDX_CFG) begin
            cond_data_o = status[tfsb_pkg::IDX_DENS_CFG];
        end else if (cond_index_i == tfsb_pkg::CIDX_CFG - 4'h1) begin
            cond_data_o = status[tfsb_pkg::IDX_OPT_CFG];
        end else begin
            cond_data_o = tfsb_pkg::BYTE_ZERO;
        end
    end

    assign hard_error_line_o = uncorrected_error_i && !corrected_error_i;
    assign forward_inhibit_o = limit_inhibit_en_i
        && status[tfsb_pkg::IDX_SUPP][tfsb_pkg::SS_LIMIT];

    // ****************************************************************
    // checks
    // ****************************************************************
    a_motion_clears: assert property (@(posedge clock_i) disable iff (rst_i)
        motion_accept_i && !clear_diag_i && !track_error_i |=>
        status[tfsb_pkg::IDX_TRACK_MAP] == 8'h00)
        else $error("track map not cleared by motion");
    a_diag_clear: assert property (@(posedge clock_i) disable iff (rst_i)
        clear_diag_i |=> status[tfsb_pkg::IDX_WR_CNT] == 8'h00
        && status[tfsb_pkg::IDX_DENS_CFG] == $past(current_density_i))
        else $error("clearing diagnostic wrong");
    a_write_count: assert property (@(posedge clock_i) disable iff (rst_i)
        write_error_i && !clear_diag_i |=>
        status[tfsb_pkg::IDX_WR_CNT] == $past(status[tfsb_pkg::IDX_WR_CNT]) + 8'h01)
        else $error("write count not incremented");
    a_read_count: assert property (@(posedge clock_i) disable iff (rst_i)
        !read_hard_error_i && !clear_diag_i |=> $stable(status[tfsb_pkg::IDX_RD_CNT]))
        else $error("read count moved without error");
    a_iface_diag: assert property (@(posedge clock_i) disable iff (rst_i)
        diag_iface_i && !diag_panel_i && !clear_diag_i |=>
        status[tfsb_pkg::IDX_DIAG_NUM][7:5] == 3'h0)
        else $error("interface diag number too wide");
    a_nrz_select: assert property (@(posedge clock_i) disable iff (rst_i)
        !clear_diag_i |=>
        status[tfsb_pkg::IDX_RD_DETAIL][tfsb_pkg::RD_NRZ] == $past(nrz_active_i))
        else $error("density bit wrong");
    a_preamble_both: assert property (@(posedge clock_i) disable iff (rst_i)
        false_preamble_i && !nrz_active_i && !clear_diag_i |=>
        status[tfsb_pkg::IDX_RD_DETAIL][1:0] == 2'h3)
        else $error("false preamble bits not both set");
    a_eot_sticky: assert property (@(posedge clock_i) disable iff (rst_i)
        status[tfsb_pkg::IDX_SUPP][tfsb_pkg::SS_EOT] && !eot_reverse_i && !clear_diag_i
        && !motion_accept_i |=> status[tfsb_pkg::IDX_SUPP][tfsb_pkg::SS_EOT])
        else $error("eot bit lost");
    a_reject_flag: assert property (@(posedge clock_i) disable iff (rst_i)
        reject_i && !clear_diag_i |=> status[tfsb_pkg::IDX_SUPP][tfsb_pkg::SS_REJECT]
        && status[tfsb_pkg::IDX_REJECT] == $past(reject_cause_i))
        else $error("reject not recorded");
    a_parity_flag: assert property (@(posedge clock_i) disable iff (rst_i)
        par_bad && ext_write_parity_en_i && !clear_diag_i |=>
        status[tfsb_pkg::IDX_SUPP][tfsb_pkg::SS_PAR])
        else $error("write parity error not flagged");
endmodule
`default_nettype wire

// File: sim/tfsb_host_model.sv
/*
 * host-side write port model: eight write data lines, parity line and strobe.
 * assumes the bench asks for a transfer with a one-cycle send_i pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module tfsb_host_model (
    input wire logic clock_i,
    input wire logic send_i,
    input wire logic [7:0] data_i,
    input wire logic bad_i,
    output logic strobe_o,
    output logic [7:0] lines_o,
    output logic parity_o
);
    int hold = 0;
    initial begin
        strobe_o = 1'b0;
        lines_o = 8'h5a;
        parity_o = 1'b0;
    end
    // odd parity over nine lines; lines scrambled once the hold has run out
    // strobe stands two edges so the three-stage synchroniser sees it settle
    always @(posedge clock_i) begin
        strobe_o <= send_i || (hold == 6);
        if (send_i) begin
            lines_o <= data_i;
            parity_o <= ~(^data_i) ^ bad_i;
            hold <= 6;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end else begin
            lines_o <= ~lines_o;
            parity_o <= ~parity_o;
        end
    end
endmodule
`default_nettype wire

// File: sim/tfsb_status_tb.sv
/*
 * self-checking bench for the tape status byte block with a host write port model.
 * assumes the block reads bytes combinationally and updates them one edge after a pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module tfsb_status_tb;
    localparam int E_MOT = 0, E_CLR = 1, E_WR = 2, E_RD = 3, E_DI = 4, E_DP = 5, E_DF = 6;
    localparam int E_SK = 7, E_TRK = 8, E_ID = 9, E_COR = 10, E_UNC = 11, E_VPE = 12;
    localparam int E_SKW = 13, E_MTD = 14, E_FPO = 15, E_FPR = 16, E_LRC = 17, E_CRC = 18;
    localparam int E_REJ = 19, E_UNF = 20, E_NRB = 21, E_DEN = 22, E_LIM = 23, E_WRN = 24;
    localparam int E_EF = 25, E_ER = 26, E_FM = 27;
    logic clock_i = 1'b0, rst_i = 1'b1, look = 1'b0, send = 1'b0, bad = 1'b0;
    logic online = 1'b1, fskip = 1'b0, nrz = 1'b0, lim_en = 1'b0, par_en = 1'b0;
    logic [27:0] ev = '0;
    logic [7:0] dcfg = 8'h00, ocfg = 8'h00, val = 8'h00, icause = 8'h00, wdat = 8'h00;
    logic [7:0] v, acc, seen, full_data, cond_data;
    logic [3:0] fidx = 4'h0;
    logic [9:0] nt;
    logic strobe, parity, hard_line, fwd_inh;
    logic [7:0] lines;
    logic [9:0] notes[$];
    int seed = 28718, n, i, fail_count = 0, samples_checked = 0;
    int cev[6] = '{E_ID, E_COR, E_VPE, E_SKW, E_MTD, E_FPR};
    logic [7:0] cbit[6] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h03};
    int nev[4] = '{E_ID, E_LRC, E_CRC, E_VPE};
    logic [7:0] nbit[4] = '{8'h00, 8'h04, 8'h02, 8'h01};
    int sev[7] = '{E_REJ, E_UNF, E_DEN, E_LIM, E_WRN, E_EF, E_FM};
    logic [7:0] sbit[7] = '{8'h80, 8'h40, 8'h08, 8'h20, 8'h10, 8'h04, 8'h02};

    always #10 clock_i = ~clock_i;

    tfsb_status tfsb_status_inst (
        .clock_i(clock_i), .rst_i(rst_i), .density_cfg_i(dcfg), .option_cfg_i(ocfg),
        .current_density_i(val), .motion_accept_i(ev[E_MOT]), .clear_diag_i(ev[E_CLR]),
        .write_error_i(ev[E_WR]), .read_hard_error_i(ev[E_RD]), .diag_iface_i(ev[E_DI]),
        .diag_panel_i(ev[E_DP]), .diag_number_i(val), .online_i(online),
        .diag_fail_i(ev[E_DF]), .diag_fail_code_i(val), .failure_skip_i(fskip),
        .skip_fail_i(ev[E_SK]), .track_error_i(ev[E_TRK]), .track_i(val),
        .nrz_active_i(nrz), .ident_found_i(ev[E_ID]), .corrected_error_i(ev[E_COR]),
        .uncorrected_error_i(ev[E_UNC]), .vertical_parity_error_i(ev[E_VPE]),
        .skew_error_i(ev[E_SKW]), .multi_track_dropout_i(ev[E_MTD]),
        .false_postamble_i(ev[E_FPO]), .false_preamble_i(ev[E_FPR]),
        .longitudinal_check_error_i(ev[E_LRC]), .cyclic_check_error_i(ev[E_CRC]),
        .reject_i(ev[E_REJ]), .reject_cause_i(val), .unfinished_i(ev[E_UNF]),
        .command_unfinished_cause_i(icause), .no_readback_during_write_i(ev[E_NRB]),
        .density_error_i(ev[E_DEN]), .density_error_cause_i(val),
        .tape_end_limit_i(ev[E_LIM]), .limit_inhibit_en_i(lim_en),
        .tape_end_warning_i(ev[E_WRN]), .eot_forward_i(ev[E_EF]), .eot_reverse_i(ev[E_ER]),
        .file_mark_i(ev[E_FM]), .block_traversed_i(ev[E_FM]),
        .ext_write_parity_en_i(par_en), .host_write_strobe_i(strobe),
        .host_write_data_lines_i(lines), .host_write_parity_i(parity),
        .full_index_i(fidx), .cond_index_i(fidx), .full_data_o(full_data),
        .cond_data_o(cond_data), .hard_error_line_o(hard_line), .forward_inhibit_o(fwd_inh)
    );

    tfsb_host_model tfsb_host_model_inst (
        .clock_i(clock_i), .send_i(send), .data_i(wdat), .bad_i(bad),
        .strobe_o(strobe), .lines_o(lines), .parity_o(parity)
    );

    // ****************************************
    // drivers, watcher and verdict
    // ****************************************
    task automatic compare(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (notes.size() != 0) fail_count++;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic pulse(input int b, input logic [7:0] d);
        @(negedge clock_i);
        ev = 28'h1 << b;
        val = d;
        @(negedge clock_i);
        ev = '0;
    endtask

    // mode 0 full byte, 1 condensed byte, 2 hard error line, 3 forward inhibit
    task automatic chk(input logic [1:0] md, input logic [3:0] ix, input logic [7:0] e);
        @(negedge clock_i);
        fidx = ix;
        notes.push_back({md, e});
        look = 1'b1;
        @(negedge clock_i);
        look = 1'b0;
    endtask

    task automatic hard(input logic [27:0] m, input logic e);
        @(negedge clock_i);
        ev = m;
        notes.push_back({2'd2, 7'h00, e});
        look = 1'b1;
        @(negedge clock_i);
        ev = '0;
        look = 1'b0;
    endtask

    always @(posedge clock_i) begin
        if (look) begin
            nt = notes.pop_front();
            case (nt[9:8])
                2'd0: seen = full_data;
                2'd1: seen = cond_data;
                2'd2: seen = {7'h00, hard_line};
                default: seen = {7'h00, fwd_inh};
            endcase
            compare(seen, nt[7:0]);
        end
    end

    initial begin
        repeat (20000) @(posedge clock_i);
        fail_count++;
        $display("[ERR] t=%0t run did not finish", $time);
        test_done();
    end

    initial begin
        dcfg = $random(seed);
        ocfg = $random(seed);
        repeat (20) @(posedge clock_i);
        @(negedge clock_i);
        rst_i = 1'b0;
        chk(0, 4'he, dcfg);
        chk(0, 4'hf, ocfg);
        chk(1, 4'h7, ocfg);
        chk(1, 4'h8, dcfg);
        for (i = 0; i < 14; i++) chk(0, i[3:0], 8'h00);
        chk(1, 4'h9, 8'h00);
        n = 256 + ($random(seed) & 7);
        for (i = 0; i < n; i++) pulse(E_WR, 8'h00);
        chk(0, 4'h0, n[7:0]);
        for (i = 0; i < 5; i++) begin
            online = (i < 3);
            pulse(E_RD, 8'h00);
        end
        online = 1'b1;
        chk(0, 4'h1, 8'h03);
        v = $random(seed) | 8'he0;
        pulse(E_DI, v);
        chk(0, 4'h2, v & 8'h1f);
        pulse(E_DP, v);
        chk(0, 4'h2, v & 8'h7f);
        v = $random(seed) | 8'h01;
        pulse(E_DF, v);
        chk(0, 4'h3, v);
        v = $random(seed);
        pulse(E_CLR, v);
        chk(0, 4'h0, 8'h00);
        chk(0, 4'hf, 8'h00);
        chk(0, 4'he, v);
        chk(1, 4'h8, v);
        online = 1'b0;
        fskip = 1'b1;
        for (i = 0; i < 3; i++) pulse(E_SK, 8'h00);
        chk(0, 4'h3, 8'h03);
        chk(1, 4'h3, 8'h03);
        online = 1'b1;
        fskip = 1'b0;
        pulse(E_WR, 8'h00);
        acc = 8'h00;
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            acc = acc | v;
            pulse(E_TRK, v);
        end
        chk(0, 4'h4, acc);
        acc = 8'h00;
        for (i = 0; i < 6; i++) begin
            acc = acc | cbit[i];
            pulse(cev[i], 8'h00);
            chk(0, 4'h5, acc);
        end
        hard((28'h1 << E_COR) | (28'h1 << E_UNC), 1'b0);
        hard(28'h1 << E_UNC, 1'b1);
        lim_en = 1'b1;
        icause = 8'h0c;
        acc = 8'h00;
        for (i = 0; i < 7; i++) begin
            acc = acc | sbit[i];
            pulse(sev[i], 8'h11 * (i + 1));
            chk(0, 4'h6, acc);
        end
        chk(0, 4'h8, 8'h11);
        chk(0, 4'h9, 8'h33);
        chk(3, 4'h0, 8'h01);
        pulse(E_ER, 8'h00);
        chk(0, 4'h6, acc & 8'hfb);
        pulse(E_NRB, 8'h00);
        chk(0, 4'h7, 8'h8c);
        icause = 8'h00;
        lim_en = 1'b0;
        chk(3, 4'h0, 8'h00);
        pulse(E_MOT, 8'h00);
        for (i = 4; i < 12; i++) chk(0, i[3:0], 8'h00);
        chk(0, 4'h0, 8'h01);
        chk(0, 4'h3, 8'h03);
        nrz = 1'b1;
        acc = 8'h80;
        for (i = 0; i < 4; i++) begin
            acc = acc | nbit[i];
            pulse(nev[i], 8'h00);
            chk(0, 4'h5, acc);
        end
        nrz = 1'b0;
        chk(0, 4'h5, 8'h07);
        for (i = 0; i < 3; i++) begin
            @(negedge clock_i);
            par_en = (i > 0);
            bad = (i != 1);
            wdat = $random(seed);
            send = 1'b1;
            @(negedge clock_i);
            send = 1'b0;
            repeat (6) @(negedge clock_i);
            chk(0, 4'h6, (i == 2) ? 8'h01 : 8'h00);
        end
        test_done();
    end
endmodule
`default_nettype wire
